// ===== hw/acs_pkg.sv
package acs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_MODE      = 8'h00;
  localparam logic [7:0] OFF_CHAN_EN   = 8'h04;
  localparam logic [7:0] OFF_CHOP_EN   = 8'h08;
  localparam logic [7:0] OFF_CONV_STAT = 8'h0C;
  localparam logic [7:0] OFF_INT_STAT  = 8'h10;
  localparam logic [7:0] OFF_INT_MASK  = 8'h14;
  localparam logic [7:0] OFF_CONV_TIME = 8'h20;
  localparam logic [7:0] OFF_DATA      = 8'h40;
  localparam logic [7:0] OFF_CHAN_STAT = 8'h60;

  // Mode register fields
  localparam int MODE_CONT_BIT   = 0;
  localparam int MODE_START_BIT  = 1;
  localparam int MODE_CH_LSB     = 4;
  localparam int MODE_CLAMP_BIT  = 8;
  localparam int MODE_RDYALL_BIT = 9;
  localparam int MODE_BIPOL_BIT  = 10;

  // Channel status fields
  localparam int CHST_READY_BIT = 0;
  localparam int CHST_SIGN_BIT  = 1;
  localparam int CHST_OVR_BIT   = 2;
  localparam int CHST_CH_LSB    = 4;

  // Converter status busy flag position
  localparam int CSTAT_BUSY_BIT = 16;

  // Interrupt event positions
  localparam int EV_DONE    = 0;
  localparam int EV_OVR     = 1;
  localparam int EV_DISCARD = 2;
  localparam int EV_W       = 3;

  // Reset values
  localparam logic [31:0] MODE_RST      = 32'h0000_0000;
  localparam logic [7:0]  CHAN_EN_RST   = 8'h01;
  localparam logic [7:0]  CHOP_EN_RST   = 8'h00;
  localparam logic [7:0]  CONV_TIME_RST = 8'h10;

  // Phase lengths in master-clock cycles
  localparam logic [15:0] SETTLE_FIRST = 16'h002B;
  localparam logic [15:0] SETTLE_CHOP  = 16'h002A;
  localparam logic [15:0] SCALE_CYC    = 16'h00A3;
  localparam logic [15:0] SAMP_MIN     = 16'h0002;

  // Coding constants
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_ONES = 16'hFFFF;
  localparam logic signed [18:0] BIPOLAR_OFS = 19'sh08000;
  localparam logic signed [18:0] UNIPOLAR_MAX = 19'sh0FFFF;

  typedef enum logic [2:0] {
    ACS_IDLE, ACS_SETTLE1, ACS_SAMP1, ACS_SETTLE2, ACS_SAMP2, ACS_SCALE
  } acs_state_t;

endpackage

// ===== hw/acs_code_if.sv
`timescale 1ns/100ps
`default_nettype none
interface acs_code_if;
  logic signed [18:0] raw;
  logic               bipolar;
  logic               clamp;
  logic        [15:0] code;
  logic               sign;
  logic               overrange_flag;

  modport coder (input raw, input bipolar, input clamp,
                 output code, output sign, output overrange_flag);
  modport seq   (output raw, output bipolar, output clamp,
                 input code, input sign, input overrange_flag);
endinterface
`default_nettype wire

// ===== hw/acs_coder.sv
`timescale 1ns/100ps
`default_nettype none
module acs_coder (
  acs_code_if.coder cif
);
  logic signed [18:0] shifted;
  logic               below;
  logic               above;

  // Output coding with optional clamping
  always_comb begin
    shifted = cif.raw + acs_pkg::BIPOLAR_OFS;
    cif.sign = cif.raw < 0;
    if (cif.bipolar) begin
      below = shifted < 0;
      above = shifted > acs_pkg::UNIPOLAR_MAX;
    end else begin
      below = cif.raw < 0;
      above = cif.raw > acs_pkg::UNIPOLAR_MAX;
    end
    cif.overrange_flag = below | above;
    if (cif.clamp && below) begin
      cif.code = acs_pkg::CODE_ZERO;
    end else if (cif.clamp && above) begin
      cif.code = acs_pkg::CODE_ONES;
    end else if (!cif.bipolar && below) begin
      cif.code = acs_pkg::CODE_ZERO;
    end else if (cif.bipolar) begin
      cif.code = shifted[15:0];
    end else begin
      cif.code = cif.raw[15:0];
    end
  end
endmodule
`default_nettype wire

// ===== hw/acs_top.sv
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Chopped cycle opens with 43 or 44 cycles of settling.
// - Sampling length comes from the channel filter_word.
// - Chopped: 42 more settling cycles, then sampling with reversed input.
// - 163-cycle scaling averages, codes and writes the data register.
// - Unchopped: one settle of 43/44, one sampling, 163-cycle scaling.
// - Ready pin forced high throughout every scaling phase.
// - Completion sets converter and channel ready bits, pin goes low (in all-enabled mode only once every enabled channel is ready).
// - Continuous mode moves straight on to the next enabled channel.
// - Conversion time and chopping held and applied per channel.
// - Modulator clock runs at half the master clock.
// - Clamp set: out-of-range result forced to all zeros or all ones.
// - Clamp clear: out-of-range results wrap, unipolar negatives give 0x0000; sign and overrange decode.
// - Overrange flag computed digitally from the result.
// - Bipolar coding: zero 0x8000, +FS 0xFFFF, -FS 0x0000, wraps.
// - Unipolar coding: zero 0x0000, FS 0xFFFF, negatives give 0x0000.
// - Reading a channel data register clears its ready bit.
// - Ready pin low on any unread data, or all enabled when selected.
// - Result finishing during a read of its own channel's data register is discarded.
module acs_top #(
  parameter int NCH = 8
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic signed [17:0] filt_data,
  output logic                    mod_clk,
  output logic      [2:0]         mux_channel,
  output logic                    chop_invert,
  output logic                    sampling,
  output logic                    ready_n,
  output logic                    irq
);

  localparam int CW  = 3;
  localparam int EVW = acs_pkg::EV_W;

  acs_code_if cif ();
  acs_pkg::acs_state_t state_ff;
  acs_pkg::acs_state_t nxt_state;
  logic [15:0]        cnt_ff;
  logic [15:0]        nxt_cnt;
  logic [CW-1:0]      ch_ff;
  logic [CW-1:0]      nxt_ch;
  logic               mod_ph_ff;
  logic               last_cyc;
  logic               done;
  logic               chop_cur;
  logic signed [17:0] samp_a_ff;
  logic signed [18:0] avg_ff;
  logic [31:0]        mode_ff;
  logic [7:0]         chan_en_ff;
  logic [7:0]         chop_en_ff;
  logic [7:0]         conv_time_ff [NCH];
  logic [15:0]        data_ff [NCH];
  logic [NCH-1:0]     rdy_ff;
  logic [NCH-1:0]     sign_ff;
  logic [NCH-1:0]     ovr_ff;
  logic [EVW-1:0]     int_stat_ff;
  logic [EVW-1:0]     int_mask_ff;
  logic [EVW-1:0]     ev;
  logic               wr_pend_ff;
  logic [7:0]         waddr_ff;
  logic [31:0]        hrdata_ff;
  logic [31:0]        rd_val;
  logic               acc;
  logic               rd_acc;
  logic               rd_data_hit;
  logic [CW-1:0]      a_ch;
  logic               mode_wr;
  logic               discard;
  logic [NCH-1:0]     en_mask;
  logic               rdy_lvl;

  // Sampling length from the filter word, never below two cycles
  function automatic logic [15:0] samp_len(input logic [7:0] fw);
    samp_len = 16'({fw, 1'b0}) + acs_pkg::SAMP_MIN;
  endfunction
  // Next enabled channel after cur, wrapping; cur if none enabled
  function automatic logic [CW-1:0] next_ch(input logic [CW-1:0] cur,
                                            input logic [NCH-1:0] en);
    logic [CW-1:0] c;
    next_ch = cur;
    for (int i = 1; i <= NCH; i++) begin
      c = CW'((int'(cur) + i) % NCH);
      if (en[c] && next_ch == cur) begin
        next_ch = c;
      end
    end
  endfunction
  // Register-window decode helpers
  function automatic logic in_win(input logic [7:0] a,
                                  input logic [7:0] base);
    in_win = a[7:5] == base[7:5] && int'(a[4:2]) < NCH;
  endfunction
  // AHB-Lite access qualification
  assign acc     = hsel && htrans[1] && hready;
  assign rd_acc  = acc && !hwrite;
  assign a_ch    = haddr[4:2];
  assign rd_data_hit = rd_acc && in_win(haddr[7:0], acs_pkg::OFF_DATA);
  assign mode_wr = wr_pend_ff && waddr_ff == acs_pkg::OFF_MODE;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign en_mask  = chan_en_ff[NCH-1:0];
  assign chop_cur = chop_en_ff[ch_ff];
  assign last_cyc = cnt_ff == 16'h0000;
  assign done     = state_ff == acs_pkg::ACS_SCALE && last_cyc;
  assign discard  = done && rd_data_hit && a_ch == ch_ff;
  // Coder hookup
  assign cif.raw     = avg_ff;
  assign cif.bipolar = mode_ff[acs_pkg::MODE_BIPOL_BIT];
  assign cif.clamp   = mode_ff[acs_pkg::MODE_CLAMP_BIT];
  acs_coder u_coder (
    .cif (cif)
  );
  // Modulator clock at half rate
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mod_ph_ff <= 1'b0;
    end else begin
      mod_ph_ff <= ~mod_ph_ff;
    end
  end

  // Phase sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = last_cyc ? cnt_ff : cnt_ff - 16'h0001;
    nxt_ch    = ch_ff;
    case (state_ff)
      acs_pkg::ACS_IDLE: begin
        nxt_cnt = 16'h0000;
      end
      acs_pkg::ACS_SETTLE1: begin
        if (last_cyc) begin
          nxt_state = acs_pkg::ACS_SAMP1;
          nxt_cnt   = samp_len(conv_time_ff[ch_ff]) - 16'h0001;
        end
      end
      acs_pkg::ACS_SAMP1: begin
        if (last_cyc && chop_cur) begin
          nxt_state = acs_pkg::ACS_SETTLE2;
          nxt_cnt   = acs_pkg::SETTLE_CHOP - 16'h0001;
        end else if (last_cyc) begin
          nxt_state = acs_pkg::ACS_SCALE;
          nxt_cnt   = acs_pkg::SCALE_CYC - 16'h0001;
        end
      end
      acs_pkg::ACS_SETTLE2: begin
        if (last_cyc) begin
          nxt_state = acs_pkg::ACS_SAMP2;
          nxt_cnt   = samp_len(conv_time_ff[ch_ff]) - 16'h0001;
        end
      end
      acs_pkg::ACS_SAMP2: begin
        if (last_cyc) begin
          nxt_state = acs_pkg::ACS_SCALE;
          nxt_cnt   = acs_pkg::SCALE_CYC - 16'h0001;
        end
      end
      acs_pkg::ACS_SCALE: begin
        if (last_cyc && mode_ff[acs_pkg::MODE_CONT_BIT]) begin
          nxt_ch    = next_ch(ch_ff, en_mask);
          nxt_state = acs_pkg::ACS_SETTLE1;
          nxt_cnt   = acs_pkg::SETTLE_FIRST - 16'h0001
                      + 16'(mod_ph_ff);
        end else if (last_cyc) begin
          nxt_state = acs_pkg::ACS_IDLE;
        end
      end
      default: begin
        nxt_state = acs_pkg::ACS_IDLE;
      end
    endcase
    // A mode write with start bit launches a fresh cycle
    if (mode_wr && hwdata[acs_pkg::MODE_START_BIT]) begin
      nxt_ch    = hwdata[acs_pkg::MODE_CH_LSB +: CW];
      nxt_state = acs_pkg::ACS_SETTLE1;
      nxt_cnt   = acs_pkg::SETTLE_FIRST - 16'h0001
                  + 16'(mod_ph_ff);
    end else if (mode_wr) begin
      nxt_state = acs_pkg::ACS_IDLE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= acs_pkg::ACS_IDLE;
      cnt_ff   <= 16'h0000;
      ch_ff    <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      ch_ff    <= nxt_ch;
    end
  end
  // Filter results captured at the end of each sampling phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_a_ff <= '0;
      avg_ff    <= '0;
    end else begin
      if (state_ff == acs_pkg::ACS_SAMP1 && last_cyc) begin
        samp_a_ff <= filt_data;
      end
      if (state_ff == acs_pkg::ACS_SAMP1 && last_cyc && !chop_cur) begin
        avg_ff <= 19'(filt_data);
      end else if (state_ff == acs_pkg::ACS_SAMP2 && last_cyc) begin
        avg_ff <= (19'(samp_a_ff) + 19'(filt_data)) >>> 1;
      end
    end
  end
  // Link-side status outputs
  assign mux_channel = 3'(ch_ff);
  assign mod_clk     = mod_ph_ff;
  assign chop_invert = state_ff == acs_pkg::ACS_SETTLE2
                       || state_ff == acs_pkg::ACS_SAMP2;
  assign sampling    = state_ff == acs_pkg::ACS_SAMP1
                       || state_ff == acs_pkg::ACS_SAMP2;
  // Data and channel status update at cycle completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NCH; i++) begin
        data_ff[i] <= 16'h0000;
      end
      sign_ff <= '0;
      ovr_ff  <= '0;
    end else if (done && !discard) begin
      data_ff[ch_ff] <= cif.code;
      sign_ff[ch_ff] <= cif.sign;
      ovr_ff[ch_ff]  <= cif.overrange_flag;
    end
  end

  // Ready bits: set on completion, cleared by read, scale or mode write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdy_ff <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (done && !discard && ch_ff == CW'(i)) begin
          rdy_ff[i] <= 1'b1;
        end else if (mode_wr) begin
          rdy_ff[i] <= 1'b0;
        end else if (rd_data_hit && a_ch == CW'(i)) begin
          rdy_ff[i] <= 1'b0;
        end else if (state_ff == acs_pkg::ACS_SCALE && ch_ff == CW'(i)) begin
          rdy_ff[i] <= 1'b0;
        end
      end
    end
  end

  // Ready pin function
  always_comb begin
    if (mode_ff[acs_pkg::MODE_RDYALL_BIT]) begin
      rdy_lvl = |en_mask && (rdy_ff & en_mask) == en_mask;
    end else begin
      rdy_lvl = |rdy_ff;
    end
    ready_n = state_ff == acs_pkg::ACS_SCALE || !rdy_lvl;
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff    <= acs_pkg::MODE_RST;
      chan_en_ff <= acs_pkg::CHAN_EN_RST;
      chop_en_ff <= acs_pkg::CHOP_EN_RST;
      int_mask_ff <= '0;
      for (int i = 0; i < NCH; i++) begin
        conv_time_ff[i] <= acs_pkg::CONV_TIME_RST;
      end
    end else if (wr_pend_ff) begin
      if (waddr_ff == acs_pkg::OFF_MODE) begin
        mode_ff <= hwdata & ~(32'h1 << acs_pkg::MODE_START_BIT);
      end else if (waddr_ff == acs_pkg::OFF_CHAN_EN) begin
        chan_en_ff <= hwdata[7:0];
      end else if (waddr_ff == acs_pkg::OFF_CHOP_EN) begin
        chop_en_ff <= hwdata[7:0];
      end else if (waddr_ff == acs_pkg::OFF_INT_MASK) begin
        int_mask_ff <= hwdata[EVW-1:0];
      end else if (in_win(waddr_ff, acs_pkg::OFF_CONV_TIME)) begin
        conv_time_ff[waddr_ff[4:2]] <= hwdata[7:0];
      end
    end
  end

  // Sticky interrupt status, set wins over write-one clear
  assign ev[acs_pkg::EV_DONE]    = done && !discard;
  assign ev[acs_pkg::EV_OVR]     = done && !discard && cif.overrange_flag;
  assign ev[acs_pkg::EV_DISCARD] = discard;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_ff <= '0;
    end else begin
      if (wr_pend_ff && waddr_ff == acs_pkg::OFF_INT_STAT) begin
        int_stat_ff <= (int_stat_ff & ~hwdata[EVW-1:0]) | ev;
      end else begin
        int_stat_ff <= int_stat_ff | ev;
      end
    end
  end

  assign irq = |(int_stat_ff & int_mask_ff);

  // Read multiplexer for the address phase
  always_comb begin
    rd_val = 32'h0000_0000;
    if (haddr[7:0] == acs_pkg::OFF_MODE) begin
      rd_val = mode_ff;
    end else if (haddr[7:0] == acs_pkg::OFF_CHAN_EN) begin
      rd_val[7:0] = chan_en_ff;
    end else if (haddr[7:0] == acs_pkg::OFF_CHOP_EN) begin
      rd_val[7:0] = chop_en_ff;
    end else if (haddr[7:0] == acs_pkg::OFF_CONV_STAT) begin
      rd_val[NCH-1:0] = rdy_ff;
      rd_val[acs_pkg::CSTAT_BUSY_BIT] = state_ff != acs_pkg::ACS_IDLE;
    end else if (haddr[7:0] == acs_pkg::OFF_INT_STAT) begin
      rd_val[EVW-1:0] = int_stat_ff;
    end else if (haddr[7:0] == acs_pkg::OFF_INT_MASK) begin
      rd_val[EVW-1:0] = int_mask_ff;
    end else if (in_win(haddr[7:0], acs_pkg::OFF_CONV_TIME)) begin
      rd_val[7:0] = conv_time_ff[a_ch];
    end else if (in_win(haddr[7:0], acs_pkg::OFF_DATA)) begin
      rd_val[15:0] = data_ff[a_ch];
    end else if (in_win(haddr[7:0], acs_pkg::OFF_CHAN_STAT)) begin
      rd_val[acs_pkg::CHST_READY_BIT] = rdy_ff[a_ch];
      rd_val[acs_pkg::CHST_SIGN_BIT]  = sign_ff[a_ch];
      rd_val[acs_pkg::CHST_OVR_BIT]   = ovr_ff[a_ch];
      rd_val[acs_pkg::CHST_CH_LSB +: CW] = a_ch;
    end
  end

  // Bus address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      waddr_ff   <= 8'h00;
      hrdata_ff  <= 32'h0000_0000;
    end else begin
      wr_pend_ff <= acc && hwrite;
      if (acc) begin
        waddr_ff <= haddr[7:0];
      end
      if (rd_acc) begin
        hrdata_ff <= rd_val;
      end
    end
  end

endmodule
`default_nettype wire

// ===== tb/acs_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module acs_top_props (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       mod_clk,
  input wire logic [2:0] mux_channel,
  input wire logic       chop_invert,
  input wire logic       sampling,
  input wire logic       ready_n
);
  logic       samp_d_ff;
  logic       chop_d_ff;
  logic [7:0] scl_cnt_ff;
  logic [7:0] low_cnt_ff;
  logic [9:0] hi_cnt_ff;
  logic [9:0] len1_ff;
  logic       scale_start;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Sampling just ended with no reversed half to follow
  assign scale_start = samp_d_ff && !sampling && !chop_invert;

  // Delayed phase outputs, sampling length, first-half length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_d_ff <= 1'b0;
      chop_d_ff <= 1'b0;
      hi_cnt_ff <= 10'h000;
      len1_ff   <= 10'h000;
    end else begin
      samp_d_ff <= sampling;
      chop_d_ff <= chop_invert;
      hi_cnt_ff <= sampling ? hi_cnt_ff + 10'h001 : 10'h000;
      if (samp_d_ff && !sampling && !chop_d_ff) begin
        len1_ff <= hi_cnt_ff;
      end
    end
  end

  // Scaling cycles left, the current one included
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_cnt_ff <= 8'h00;
    end else if (scale_start) begin
      scl_cnt_ff <= 8'hA2;
    end else if (scl_cnt_ff != 8'h00) begin
      scl_cnt_ff <= scl_cnt_ff - 8'h01;
    end
  end

  // Consecutive cycles without sampling, saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_cnt_ff <= 8'h00;
    end else if (sampling) begin
      low_cnt_ff <= 8'h00;
    end else if (low_cnt_ff != 8'hFF) begin
      low_cnt_ff <= low_cnt_ff + 8'h01;
    end
  end

  sequence s_after_first;
    !sampling ##0 samp_d_ff;
  endsequence

  sequence s_second_end;
    $fell(sampling) ##0 chop_d_ff;
  endsequence

  mclk_half_a: assert property (
    mod_clk |=> !mod_clk ##1 mod_clk)
    else $error("modulator clock not half rate");
  scale_ready_a: assert property (
    (scale_start || scl_cnt_ff != 8'h00) |-> ready_n)
    else $error("ready pin low in scaling");
  settle_first_a: assert property (
    $rose(sampling) && !chop_invert |-> low_cnt_ff >= 8'h2B)
    else $error("first settling too short");
  settle_chop_a: assert property (
    $rose(sampling) && chop_invert |-> low_cnt_ff == 8'h2A)
    else $error("second settling not 42 cycles");
  samp_len_a: assert property (
    $fell(sampling) |-> !hi_cnt_ff[0] && hi_cnt_ff >= 10'h002)
    else $error("sampling length not from filter word");
  chop_order_a: assert property (
    $rose(chop_invert) |-> s_after_first)
    else $error("reversal not after first sampling");
  samp_match_a: assert property (
    s_second_end |-> hi_cnt_ff == len1_ff)
    else $error("chopped halves differ in length");
  mux_hold_a: assert property (
    sampling && samp_d_ff |-> $stable(mux_channel))
    else $error("channel changed while sampling");
endmodule

bind acs_top acs_top_props u_props (.hclk(hclk), .hresetn(hresetn),
  .mod_clk(mod_clk), .mux_channel(mux_channel), .chop_invert(chop_invert),
  .sampling(sampling), .ready_n(ready_n));
`default_nettype wire

// ===== tb/acs_filt_model.sv
`timescale 1ns/100ps
`default_nettype none
module acs_filt_model (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               sampling,
  input  wire logic signed [17:0] level,
  output logic signed [17:0]      filt_data
);
  logic [17:0] junk_ff;

  // Changing pattern so a stale filter word never looks valid
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      junk_ff <= 18'h2AAAA;
    end else begin
      junk_ff <= ~junk_ff + 18'h00001;
    end
  end

  // Offset-free input: both chopped halves give the same level
  assign filt_data = sampling ? level : junk_ff;
endmodule
`default_nettype wire

// ===== tb/tb_adc_conversion_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_adc_conversion_sequencer;
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic        [31:0] haddr;
  logic        [1:0]  htrans;
  logic               hwrite;
  logic        [31:0] hwdata;
  logic        [31:0] hrdata;
  logic               hreadyout;
  logic               hresp;
  logic signed [17:0] filt_data;
  logic signed [17:0] level;
  logic               mod_clk;
  logic        [2:0]  mux_channel;
  logic               chop_invert;
  logic               sampling;
  logic               ready_n;
  logic               irq;
  logic        [31:0] rd;
  logic        [31:0] msk;
  int                 miscompares;
  int                 checks_done;
  int                 cycles;
  int                 n;
  // Cases: bipolar, clamp, level, data, sign, overrange
  logic        [51:0] tv [14] = '{
    52'h1_0_00000_8000_0_0, 52'h1_0_07FFF_FFFF_0_0, 52'h1_0_38000_0000_1_0,
    52'h1_0_3FFFF_7FFF_1_0, 52'h1_0_08000_0000_0_1, 52'h1_0_37FFF_FFFF_1_1,
    52'h0_0_00000_0000_0_0, 52'h0_0_0FFFF_FFFF_0_0, 52'h0_0_10000_0000_0_1,
    52'h0_0_3FFFF_0000_1_1, 52'h1_1_08000_FFFF_0_1, 52'h1_1_37FFF_0000_1_1,
    52'h0_1_10000_FFFF_0_1, 52'h0_1_3FFFF_0000_1_1};

  acs_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .filt_data(filt_data), .mod_clk(mod_clk),
    .mux_channel(mux_channel), .chop_invert(chop_invert),
    .sampling(sampling), .ready_n(ready_n), .irq(irq));

  acs_filt_model u_filt (.hclk(hclk), .hresetn(hresetn),
    .sampling(sampling), .level(level), .filt_data(filt_data));

  // Master clock, 8 ns
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  // Hang guard
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s is %h not %h", $time, what, got, exp);
    end
  endtask

  // One single AHB-Lite word transfer
  task automatic xfer(input logic wr_en, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr_en;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdck(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string what);
    xfer(1'b0, a, 32'h0000_0000);
    check(rd & m, e, what);
  endtask

  task automatic step();
    @(posedge hclk);
    #1;
  endtask

  // Cycles from start until the ready pin falls
  task automatic wait_rdy(output int k);
    k = 0;
    do begin
      step();
      k++;
    end while (ready_n !== 1'b0 && k < 2000);
  endtask

  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0000_0000;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0000_0000;
    level   = 18'h00000;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values and an unmapped hole
    rdck(acs_pkg::OFF_MODE, 32'hFFFF_FFFF, 32'h0000_0000, "mode");
    rdck(acs_pkg::OFF_CHAN_EN, 32'hFFFF_FFFF, 32'h0000_0001, "chan en");
    rdck(acs_pkg::OFF_CHOP_EN, 32'hFFFF_FFFF, 32'h0000_0000, "chop en");
    rdck(acs_pkg::OFF_CONV_TIME, 32'hFFFF_FFFF, 32'h0000_0010, "fw");
    rdck(8'h80, 32'hFFFF_FFFF, 32'h0000_0000, "hole");
    wr(acs_pkg::OFF_INT_MASK, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000, "irq idle");
    // Single conversions on channel 0 over the coding table
    for (int i = 0; i < 14; i++) begin
      level <= tv[i][41:24];
      msk = (tv[i][7:4] == 4'hF) ? 32'h0000_0071 : 32'h0000_0077;
      wr(acs_pkg::OFF_MODE, {21'h0, tv[i][48], 1'b0, tv[i][44], 8'h02});
      wait_rdy(n);
      check({31'h0, n >= 240 && n <= 241}, 32'h1, "cycle length");
      rdck(acs_pkg::OFF_CONV_STAT, 32'h1, 32'h1, "conv ready");
      rdck(acs_pkg::OFF_CHAN_STAT, msk,
           {29'h0, tv[i][0], tv[i][4], 1'b1} & msk, "chan stat");
      rdck(acs_pkg::OFF_DATA, 32'hFFFF, {16'h0, tv[i][23:8]}, "data");
      check({31'h0, ready_n}, 32'h1, "pin after read");
      rdck(acs_pkg::OFF_CONV_STAT, 32'h0001_00FF, 32'h0, "idle");
      check({31'h0, sampling}, 32'h0, "no restart");
    end
    // Done and overrange events, mask and clear
    rdck(acs_pkg::OFF_INT_STAT, 32'h7, 32'h3, "events");
    check({31'h0, irq}, 32'h1, "irq done");
    wr(acs_pkg::OFF_INT_STAT, 32'h0000_0001);
    step();
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(acs_pkg::OFF_INT_MASK, 32'h0000_0002);
    step();
    check({31'h0, irq}, 32'h1, "irq ovr");
    wr(acs_pkg::OFF_INT_STAT, 32'h0000_0002);
    step();
    check({31'h0, irq}, 32'h0, "irq cleared");
    // Continuous on ch0 plain and ch1 chopped, ready when all hold data
    wr(acs_pkg::OFF_CHAN_EN, 32'h0000_0003);
    wr(acs_pkg::OFF_CHOP_EN, 32'h0000_0002);
    wr(acs_pkg::OFF_CONV_TIME + 8'h04, 32'h0000_0005);
    level <= 18'h00100;
    wr(acs_pkg::OFF_MODE, 32'h0000_0203);
    wait_rdy(n);
    check({31'h0, n >= 512 && n <= 514}, 32'h1, "sequence");
    check({29'h0, mux_channel}, 32'h0, "wrap to ch0");
    rdck(acs_pkg::OFF_CONV_STAT, 32'hFF, 32'h3, "both ready");
    rdck(acs_pkg::OFF_DATA + 8'h04, 32'hFFFF, 32'h0100, "ch1 avg");
    rdck(acs_pkg::OFF_CHAN_STAT + 8'h04, 32'h77, 32'h10, "ch1 st");
    check({31'h0, ready_n}, 32'h1, "not all ready");
    rdck(acs_pkg::OFF_DATA, 32'hFFFF, 32'h0100, "ch0 data");
    wr(acs_pkg::OFF_MODE, 32'h0000_0000);
    step();
    rdck(acs_pkg::OFF_CONV_STAT, 32'h0001_00FF, 32'h0, "stopped");
    report_and_stop();
  end
endmodule
`default_nettype wire
